// ---- shared/ccr_pkg.sv ----
/*
 * Constants and carrier types for the controller capability report.
 * Assumes byte offsets are counted from the start of the controller
 * identification structure, and all users share one clock.
 */
package ccr_pkg;

    // Byte offsets inside the identification structure
    localparam logic [11:0] CCR_OFF_MAX_XFER  = 12'h04D;
    localparam logic [11:0] CCR_OFF_CTRL_ID_L = 12'h04E;
    localparam logic [11:0] CCR_OFF_CTRL_ID_H = 12'h04F;
    localparam logic [11:0] CCR_OFF_OPT_CMD_L = 12'h100;
    localparam logic [11:0] CCR_OFF_OPT_CMD_H = 12'h101;
    localparam logic [11:0] CCR_OFF_ABORT_LIM = 12'h102;
    localparam logic [11:0] CCR_OFF_EVENT_LIM = 12'h103;
    localparam logic [11:0] CCR_OFF_FW_CAPS   = 12'h104;

    // Optional command support word fields
    localparam int CCR_OPT_SECURITY_BIT = 0;
    localparam int CCR_OPT_FORMAT_BIT   = 1;
    localparam int CCR_OPT_FIRMWARE_BIT = 2;

    // Firmware update byte fields
    localparam int CCR_FW_SLOT1_RO_BIT = 0;
    localparam int CCR_FW_SLOTS_LSB    = 1;
    localparam int CCR_FW_SLOTS_MSB    = 3;
    localparam int CCR_FW_SLOTS_MIN    = 1;
    localparam int CCR_FW_SLOTS_MAX    = 7;

    // Structure selector value for the controller structure
    localparam logic [1:0] CCR_SEL_CONTROLLER = 2'h1;

    // Log2 of the 4 KiB base of the minimum memory page size
    localparam logic [8:0] CCR_PAGE_BASE_EXP = 9'h00C;

    // Reset values of registered outputs
    localparam logic [7:0] CCR_RST_BYTE   = 8'h00;
    localparam logic [7:0] CCR_RST_STATUS = 8'h00;

    // Command widths
    localparam int CCR_LEN_W = 32;
    localparam int CCR_TAG_W = 16;

    typedef struct packed {
        logic                 valid;
        logic [CCR_TAG_W-1:0] tag;
        logic [CCR_LEN_W-1:0] data_bytes;
        logic [CCR_LEN_W-1:0] meta_bytes;
        logic                 meta_interleaved;
    } ccr_cmd_t;

    typedef struct packed {
        logic                 valid;
        logic [CCR_TAG_W-1:0] tag;
        logic                 abort;
        logic [7:0]           status;
    } ccr_verdict_t;

endpackage

// ---- hdl/ccr_size_check.sv ----
/*
 * Transfer size gate: compares each submitted command against the
 * reported limit and answers one cycle later with pass or abort.
 * Assumes commands come from logic on the same clock.
 */
module ccr_size_check #(
    parameter logic [7:0] INVALID_FIELD_STATUS = 8'h02
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // Limit settings
    input  wire logic [7:0]        max_xfer_exp_in,
    input  wire logic [3:0]        min_page_exp_in,
    // Command and verdict
    input  wire ccr_pkg::ccr_cmd_t     cmd_in,
    output      ccr_pkg::ccr_verdict_t verdict_out
);
    import ccr_pkg::*;

    ccr_verdict_t verdict;
    ccr_verdict_t next_verdict;
    logic [CCR_LEN_W:0] total;
    logic               over;

    // True when total is above 2**exp; big exponents never trip
    function automatic logic exceeds(input logic [CCR_LEN_W:0] t, input logic [8:0] e);
        logic [CCR_LEN_W:0] lim;
        lim = '0;
        if (e > 9'(CCR_LEN_W))
            return 1'b0;
        lim[e[5:0]] = 1'b1;
        return t > lim;
    endfunction

    always_comb begin
        total = {1'b0, cmd_in.data_bytes};
        if (cmd_in.meta_interleaved)
            total = total + {1'b0, cmd_in.meta_bytes};
        over = (max_xfer_exp_in != 8'h00) &&
               exceeds(total, CCR_PAGE_BASE_EXP + 9'(min_page_exp_in) + 9'(max_xfer_exp_in));
        next_verdict        = '0;
        next_verdict.valid  = cmd_in.valid;
        next_verdict.tag    = cmd_in.tag;
        next_verdict.abort  = cmd_in.valid && over;
        next_verdict.status = (cmd_in.valid && over) ? INVALID_FIELD_STATUS : CCR_RST_STATUS;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            verdict <= '0;
        else
            verdict <= next_verdict;
    end

    assign verdict_out = verdict;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_abort_oversize;
        cmd_in.valid && max_xfer_exp_in != 8'h00
            && exceeds({1'b0, cmd_in.data_bytes},
                       CCR_PAGE_BASE_EXP + 9'(min_page_exp_in) + 9'(max_xfer_exp_in))
            |=> verdict.valid && verdict.abort && verdict.status == INVALID_FIELD_STATUS;
    endproperty
    a_abort_oversize: assert property (p_abort_oversize) else $error("oversize command not aborted");

    property p_no_limit;
        cmd_in.valid && max_xfer_exp_in == 8'h00 |=> verdict.valid && !verdict.abort;
    endproperty
    a_no_limit: assert property (p_no_limit) else $error("abort while limit is zero");

    property p_meta_counted;
        cmd_in.valid && max_xfer_exp_in != 8'h00 && cmd_in.meta_interleaved
            && exceeds({1'b0, cmd_in.data_bytes} + {1'b0, cmd_in.meta_bytes},
                       CCR_PAGE_BASE_EXP + 9'(min_page_exp_in) + 9'(max_xfer_exp_in))
            |=> verdict.abort;
    endproperty
    a_meta_counted: assert property (p_meta_counted) else $error("interleaved metadata ignored");

    property p_tag_kept;
        cmd_in.valid |=> verdict.valid && verdict.tag == $past(cmd_in.tag);
    endproperty
    a_tag_kept: assert property (p_tag_kept) else $error("verdict tag or timing wrong");

    c_abort: cover property (cmd_in.valid && over ##1 verdict.abort);
    c_pass_meta: cover property (cmd_in.valid && cmd_in.meta_interleaved && !over);

endmodule // ccr_size_check

// ---- hdl/ccr_top.sv ----
/*
 * Controller capability report: read-only bytes 77..260 of the
 * controller identification structure, plus the transfer size gate
 * that enforces the reported limit on submitted commands.
 * Assumes the command front end delivers identify reads byte by byte
 * and submitted commands on the same clock; no pin is asynchronous.
 */
// Notes on behaviour
// - Commands moving more data than the reported limit abort with invalid-field status.
// - Limit byte is exponent n; limit is 2**n times minimum page size.
// - Limit byte zero means no transfer size limit at all.
// - Interleaved metadata counts toward the size that is checked.
// - Two-byte controller identifier, unique within the storage subsystem.
// - Command support bit 2 shows firmware activate and download support.
// - Command support bit 1 shows format command support.
// - Command support bit 0 shows security send and receive support.
// - Command support bits 15 to 3 are reserved and read zero.
// - Abort limit byte gives outstanding abort count minus one.
// - At least four outstanding aborts should be accepted.
// - Event request limit byte gives outstanding event requests minus one.
// - At least four outstanding event requests should be accepted.
// - Firmware byte bits 3 to 1 give the number of slots.
// - Slot count lies between one and seven.
// - Firmware byte bits 7 to 4 are reserved and read zero.
// - Firmware byte bit 0 set means slot one is read-only.
// - Identify with selector one returns the controller structure.
module ccr_top #(
    parameter logic [7:0]  MAX_XFER_EXP         = 8'h05,
    parameter logic [15:0] CONTROLLER_ID        = 16'h0001, // arbitrary value
    parameter bit          HAS_SECURITY_CMDS    = 1'b0,
    parameter bit          HAS_FORMAT_CMD       = 1'b1,
    parameter bit          HAS_FIRMWARE_CMDS    = 1'b1,
    parameter int          ABORTS_OUTSTANDING   = 4,
    parameter int          EVENTS_OUTSTANDING   = 4,
    parameter int          FIRMWARE_SLOTS       = 2,
    parameter bit          SLOT1_READ_ONLY      = 1'b0,
    parameter logic [7:0]  INVALID_FIELD_STATUS = 8'h02
) (
    // Clock and reset
    input  wire logic                  CLK_IN,
    input  wire logic                  SYS_RST_IN,
    // Identify byte read
    input  wire logic                  RD_REQ_IN,
    input  wire logic [1:0]            RD_SEL_IN,
    input  wire logic [11:0]           RD_ADDR_IN,
    output      logic                  RD_READY_OUT,
    output      logic                  RD_VALID_OUT,
    output      logic [7:0]            RD_DATA_OUT,
    output      logic                  RD_SEL_ERR_OUT,
    // Host write attempts, always discarded
    input  wire logic                  WR_REQ_IN,
    input  wire logic [11:0]           WR_ADDR_IN,
    input  wire logic [7:0]            WR_DATA_IN,
    // Controller page size setting
    input  wire logic [3:0]            MIN_PAGE_EXP_IN,
    // Submitted command and verdict
    input  wire ccr_pkg::ccr_cmd_t     CMD_IN,
    output      ccr_pkg::ccr_verdict_t VERDICT_OUT
);
    import ccr_pkg::*;

    // Elaboration checks
    if (FIRMWARE_SLOTS < CCR_FW_SLOTS_MIN || FIRMWARE_SLOTS > CCR_FW_SLOTS_MAX) begin : g_bad_slots
        $error("firmware slot count out of range");
    end
    if (ABORTS_OUTSTANDING < 4 || ABORTS_OUTSTANDING > 256) begin : g_bad_aborts
        $error("abort limit below four or above a byte");
    end
    if (EVENTS_OUTSTANDING < 4 || EVENTS_OUTSTANDING > 256) begin : g_bad_events
        $error("event limit below four or above a byte");
    end

    typedef enum logic [1:0] {
        CCR_ST_IDLE  = 2'b01,
        CCR_ST_REPLY = 2'b10
    } ccr_state_t;

    // Fixed field images
    localparam logic [15:0] OPT_CMD_WORD = 16'(
        (HAS_SECURITY_CMDS << CCR_OPT_SECURITY_BIT) |
        (HAS_FORMAT_CMD    << CCR_OPT_FORMAT_BIT)   |
        (HAS_FIRMWARE_CMDS << CCR_OPT_FIRMWARE_BIT));
    localparam logic [7:0]  ABORT_LIM_BYTE = 8'(ABORTS_OUTSTANDING - 1);
    localparam logic [7:0]  EVENT_LIM_BYTE = 8'(EVENTS_OUTSTANDING - 1);
    localparam logic [7:0]  FW_CAPS_BYTE   = 8'(
        (FIRMWARE_SLOTS << CCR_FW_SLOTS_LSB) |
        (SLOT1_READ_ONLY << CCR_FW_SLOT1_RO_BIT));

    // Byte image of the structure; neighbouring fields read zero here
    function automatic logic [7:0] id_byte(input logic [11:0] a);
        case (a)
            CCR_OFF_MAX_XFER:  return MAX_XFER_EXP;
            CCR_OFF_CTRL_ID_L: return CONTROLLER_ID[7:0];
            CCR_OFF_CTRL_ID_H: return CONTROLLER_ID[15:8];
            CCR_OFF_OPT_CMD_L: return OPT_CMD_WORD[7:0];
            CCR_OFF_OPT_CMD_H: return OPT_CMD_WORD[15:8];
            CCR_OFF_ABORT_LIM: return ABORT_LIM_BYTE;
            CCR_OFF_EVENT_LIM: return EVENT_LIM_BYTE;
            CCR_OFF_FW_CAPS:   return FW_CAPS_BYTE;
            default:           return CCR_RST_BYTE;
        endcase
    endfunction

    ccr_state_t state;
    ccr_state_t next_state;
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;
    logic       sel_err;
    logic       next_sel_err;
    logic [11:0] rd_addr;
    logic [11:0] next_rd_addr;

    // Write port has no sink: the record is fixed at build time
    logic wr_seen;
    assign wr_seen = WR_REQ_IN;

    always_comb begin
        next_state   = state;
        next_rd_data = rd_data;
        next_sel_err = sel_err;
        next_rd_addr = rd_addr;
        case (state)
            CCR_ST_IDLE: begin
                if (RD_REQ_IN) begin
                    next_state   = CCR_ST_REPLY;
                    next_rd_addr = RD_ADDR_IN;
                    // Only the controller selector reaches this record
                    if (RD_SEL_IN == CCR_SEL_CONTROLLER) begin
                        next_rd_data = id_byte(RD_ADDR_IN);
                        next_sel_err = 1'b0;
                    end else begin
                        next_rd_data = CCR_RST_BYTE;
                        next_sel_err = 1'b1;
                    end
                end
            end
            CCR_ST_REPLY: begin
                next_state = CCR_ST_IDLE;
            end
            default: begin
                next_state = CCR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state   <= CCR_ST_IDLE;
            rd_data <= CCR_RST_BYTE;
            sel_err <= 1'b0;
            rd_addr <= 12'h000;
        end else begin
            state   <= next_state;
            rd_data <= next_rd_data;
            sel_err <= next_sel_err;
            rd_addr <= next_rd_addr;
        end
    end

    // One-cycle gap per read keeps the reply stage simple
    assign RD_READY_OUT   = (state == CCR_ST_IDLE);
    assign RD_VALID_OUT   = (state == CCR_ST_REPLY);
    assign RD_DATA_OUT    = rd_data;
    assign RD_SEL_ERR_OUT = sel_err;

    // Enforces the same limit the record reports
    ccr_size_check #(
        .INVALID_FIELD_STATUS (INVALID_FIELD_STATUS)
    ) u_size_check (
        .clk_in          (CLK_IN),
        .rst_in          (SYS_RST_IN),
        .max_xfer_exp_in (MAX_XFER_EXP),
        .min_page_exp_in (MIN_PAGE_EXP_IN),
        .cmd_in          (CMD_IN),
        .verdict_out     (VERDICT_OUT)
    );

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_ctrl_read(logic [11:0] off);
        RD_REQ_IN && RD_READY_OUT && RD_SEL_IN == CCR_SEL_CONTROLLER && RD_ADDR_IN == off;
    endsequence

    property p_read_latency;
        RD_REQ_IN && RD_READY_OUT |=> RD_VALID_OUT ##1 !RD_VALID_OUT && RD_READY_OUT;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read reply timing wrong");

    property p_selector;
        RD_REQ_IN && RD_READY_OUT && RD_SEL_IN != CCR_SEL_CONTROLLER
            |=> RD_VALID_OUT && RD_SEL_ERR_OUT && RD_DATA_OUT == 8'h00;
    endproperty
    a_selector: assert property (p_selector) else $error("wrong selector answered");

    property p_max_xfer;
        s_ctrl_read(CCR_OFF_MAX_XFER) |=> RD_DATA_OUT == MAX_XFER_EXP && !RD_SEL_ERR_OUT;
    endproperty
    a_max_xfer: assert property (p_max_xfer) else $error("limit byte wrong");

    property p_ctrl_id;
        (s_ctrl_read(CCR_OFF_CTRL_ID_L) |=> RD_DATA_OUT == CONTROLLER_ID[7:0])
            and (s_ctrl_read(CCR_OFF_CTRL_ID_H) |=> RD_DATA_OUT == CONTROLLER_ID[15:8]);
    endproperty
    a_ctrl_id: assert property (p_ctrl_id) else $error("controller id byte wrong");

    property p_opt_low;
        s_ctrl_read(CCR_OFF_OPT_CMD_L) |=> RD_DATA_OUT[CCR_OPT_FIRMWARE_BIT] == HAS_FIRMWARE_CMDS
            && RD_DATA_OUT[CCR_OPT_FORMAT_BIT] == HAS_FORMAT_CMD
            && RD_DATA_OUT[CCR_OPT_SECURITY_BIT] == HAS_SECURITY_CMDS;
    endproperty
    a_opt_low: assert property (p_opt_low) else $error("command support bits wrong");

    property p_opt_reserved;
        s_ctrl_read(CCR_OFF_OPT_CMD_L) or s_ctrl_read(CCR_OFF_OPT_CMD_H)
            |=> (rd_addr == CCR_OFF_OPT_CMD_H) ? RD_DATA_OUT == 8'h00 : RD_DATA_OUT[7:3] == 5'h00;
    endproperty
    a_opt_reserved: assert property (p_opt_reserved) else $error("reserved support bits set");

    property p_abort_lim;
        s_ctrl_read(CCR_OFF_ABORT_LIM) |=> RD_DATA_OUT == 8'(ABORTS_OUTSTANDING - 1) && RD_DATA_OUT >= 8'h03;
    endproperty
    a_abort_lim: assert property (p_abort_lim) else $error("abort limit byte wrong");

    property p_event_lim;
        s_ctrl_read(CCR_OFF_EVENT_LIM) |=> RD_DATA_OUT == 8'(EVENTS_OUTSTANDING - 1) && RD_DATA_OUT >= 8'h03;
    endproperty
    a_event_lim: assert property (p_event_lim) else $error("event limit byte wrong");

    property p_fw_caps;
        s_ctrl_read(CCR_OFF_FW_CAPS) |=> RD_DATA_OUT[7:4] == 4'h0
            && RD_DATA_OUT[CCR_FW_SLOTS_MSB:CCR_FW_SLOTS_LSB] == 3'(FIRMWARE_SLOTS)
            && RD_DATA_OUT[CCR_FW_SLOTS_MSB:CCR_FW_SLOTS_LSB] != 3'h0
            && RD_DATA_OUT[CCR_FW_SLOT1_RO_BIT] == SLOT1_READ_ONLY;
    endproperty
    a_fw_caps: assert property (p_fw_caps) else $error("firmware byte wrong");

    property p_write_no_effect;
        wr_seen ##[1:4] s_ctrl_read(CCR_OFF_MAX_XFER) |=> RD_DATA_OUT == MAX_XFER_EXP;
    endproperty
    a_write_no_effect: assert property (p_write_no_effect) else $error("write changed record");

    property p_verdict_limit;
        CMD_IN.valid && MAX_XFER_EXP != 8'h00 && !CMD_IN.meta_interleaved && MIN_PAGE_EXP_IN == 4'h0
            && CMD_IN.data_bytes == (32'h1 << (MAX_XFER_EXP + 8'h0C)) + 32'h1
            && MAX_XFER_EXP < 8'h13
            |=> VERDICT_OUT.abort && VERDICT_OUT.status == INVALID_FIELD_STATUS;
    endproperty
    a_verdict_limit: assert property (p_verdict_limit) else $error("one byte over limit passed");

    c_read_fw: cover property (s_ctrl_read(CCR_OFF_FW_CAPS) ##1 RD_VALID_OUT);
    c_bad_sel: cover property (RD_VALID_OUT && RD_SEL_ERR_OUT);
    c_write_try: cover property (WR_REQ_IN && RD_REQ_IN);
    c_abort: cover property (VERDICT_OUT.valid && VERDICT_OUT.abort);

endmodule // ccr_top

// ---- tb/ccr_host_model.sv ----
/*
 * Host model: issues identify byte reads, write attempts and
 * submitted commands toward the capability report.
 * Assumes one shared clock; requests change at the falling edge.
 */
module ccr_host_model (
    // Clock and read replies
    input  wire logic              clk_in,
    input  wire logic              rd_ready_in,
    input  wire logic              rd_valid_in,
    input  wire logic [7:0]        rd_data_in,
    input  wire logic              rd_sel_err_in,
    // Read requests
    output logic                   rd_req_out,
    output logic [1:0]             rd_sel_out,
    output logic [11:0]            rd_addr_out,
    // Write attempts
    output logic                   wr_req_out,
    output logic [11:0]            wr_addr_out,
    output logic [7:0]             wr_data_out,
    // Submitted commands
    output ccr_pkg::ccr_cmd_t      cmd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;

    initial begin
        rd_req_out  = 1'b0;
        rd_sel_out  = 2'h2;
        rd_addr_out = 12'hFFF;
        wr_req_out  = 1'b0;
        wr_addr_out = 12'hFFF;
        wr_data_out = 8'hFF;
        cmd_out     = '0;
    end

    // Request held until taken, eight cycles at most; released lines show the inverse, not stale data
    task automatic read_byte(input logic [1:0] sel, input logic [11:0] addr,
                             output logic [7:0] data, output logic err, output bit ok);
        ok = 1'b0;
        @(negedge clk_in);
        rd_req_out  = 1'b1;
        rd_sel_out  = sel;  // Controller structure uses selector 01
        rd_addr_out = addr;
        // Ready sampled at the falling edge, where it has settled
        for (int i = 0; i < 8 && !ok; i++) begin
            if (i > 0) begin
                @(negedge clk_in);
            end
            ok = (rd_ready_in === 1'b1);
            @(posedge clk_in);
        end
        #1;
        ok   = ok && (rd_valid_in === 1'b1);
        data = rd_data_in;
        err  = rd_sel_err_in;
        @(negedge clk_in);
        rd_req_out  = 1'b0;
        rd_sel_out  = ~sel;
        rd_addr_out = ~addr;
    endtask

    task automatic write_byte(input logic [11:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        wr_req_out  = 1'b1;
        wr_addr_out = addr;
        wr_data_out = data;
        @(negedge clk_in);
        wr_req_out  = 1'b0;
        wr_addr_out = ~addr;
        wr_data_out = ~data;
    endtask

    // Caller is at a falling edge; returns just after the taking edge
    task automatic cmd_beat(input ccr_cmd_t c);
        cmd_out = c;
        @(posedge clk_in);
        #1;
    endtask

    task automatic cmd_idle();
        cmd_out = {1'b0, ~cmd_out[$bits(ccr_cmd_t)-2:0]};
    endtask
endmodule // ccr_host_model

// ---- tb/tb_top.sv ----
/*
 * Testbench for the capability report: identify reads, write attempts
 * and the transfer size gate, judged against the parameters set here.
 * Assumes the host model drives all request pins on the falling edge.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;

    localparam logic [7:0]  EXP  = 8'h05;
    localparam logic [15:0] CID  = 16'hA5C3; // Arbitrary value
    localparam bit          SEC  = 1'b1;
    localparam bit          FMT  = 1'b0;
    localparam bit          FW   = 1'b1;
    localparam int          ABT  = 4;
    localparam int          EVT  = 6;
    localparam int          SLOT = 7;
    localparam bit          RO   = 1'b1;
    localparam logic [7:0]  INV  = 8'h02;

    logic           clk_in, sys_rst_in, rd_req, rd_ready, rd_valid, rd_sel_err, wr_req;
    logic [1:0]     rd_sel;
    logic [11:0]    rd_addr, wr_addr;
    logic [7:0]     rd_data, wr_data;
    logic [3:0]     min_page_exp;
    ccr_cmd_t       cmd;
    ccr_verdict_t   verdict, verdict_nolim;
    int             err_count = 0;
    int             n_compared = 0;

    ccr_top #(.MAX_XFER_EXP(EXP), .CONTROLLER_ID(CID), .HAS_SECURITY_CMDS(SEC), .HAS_FORMAT_CMD(FMT),
              .HAS_FIRMWARE_CMDS(FW), .ABORTS_OUTSTANDING(ABT), .EVENTS_OUTSTANDING(EVT),
              .FIRMWARE_SLOTS(SLOT), .SLOT1_READ_ONLY(RO), .INVALID_FIELD_STATUS(INV)) DUT (
        .CLK_IN(clk_in), .SYS_RST_IN(sys_rst_in), .RD_REQ_IN(rd_req), .RD_SEL_IN(rd_sel),
        .RD_ADDR_IN(rd_addr), .RD_READY_OUT(rd_ready), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
        .RD_SEL_ERR_OUT(rd_sel_err), .WR_REQ_IN(wr_req), .WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data),
        .MIN_PAGE_EXP_IN(min_page_exp), .CMD_IN(cmd), .VERDICT_OUT(verdict));

    // Second gate with a zero limit byte, sharing all stimulus
    ccr_top #(.MAX_XFER_EXP(8'h00)) DUT_NOLIM (
        .CLK_IN(clk_in), .SYS_RST_IN(sys_rst_in), .RD_REQ_IN(rd_req), .RD_SEL_IN(rd_sel),
        .RD_ADDR_IN(rd_addr), .RD_READY_OUT(), .RD_VALID_OUT(), .RD_DATA_OUT(), .RD_SEL_ERR_OUT(),
        .WR_REQ_IN(wr_req), .WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data),
        .MIN_PAGE_EXP_IN(min_page_exp), .CMD_IN(cmd), .VERDICT_OUT(verdict_nolim));

    ccr_host_model host (
        .clk_in(clk_in), .rd_ready_in(rd_ready), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
        .rd_sel_err_in(rd_sel_err), .rd_req_out(rd_req), .rd_sel_out(rd_sel), .rd_addr_out(rd_addr),
        .wr_req_out(wr_req), .wr_addr_out(wr_addr), .wr_data_out(wr_data), .cmd_out(cmd));

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic rd(input logic [1:0] sel, input logic [11:0] addr, input logic [7:0] exp, input logic e_err);
        logic [7:0] d;
        logic       e;
        bit         ok;
        host.read_byte(sel, addr, d, e, ok);
        check(ok, 1'b1, "read reply pulse");
        if (!ok) begin
            conclude();
        end
        check(d, exp, "read data");
        check(e, e_err, "selector flag");
    endtask

    task automatic test_reset();
        check({rd_ready, rd_valid, rd_data, rd_sel_err}, {1'b1, 1'b0, 8'h00, 1'b0}, "read side after reset");
        check(verdict, '0, "verdict after reset");
        $display("test_reset done");
    endtask

    // Second pass writes garbage first: fields must not move
    task automatic test_identify();
        logic [11:0] a [12] = '{12'h04D, 12'h04E, 12'h04F, 12'h100, 12'h101, 12'h102,
                                12'h103, 12'h104, 12'h04C, 12'h050, 12'h0FF, 12'h105};
        logic [7:0]  e [12] = '{EXP, CID[7:0], CID[15:8], {5'h00, FW, FMT, SEC}, 8'h00, 8'(ABT - 1),
                                8'(EVT - 1), {4'h0, 3'(SLOT), RO}, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 12; i++) begin
                if (p == 1) begin
                    host.write_byte(a[i], ~e[i]);
                end
                rd(2'h1, a[i], e[i], 1'b0);
            end
        end
        $display("test_identify done");
    endtask

    task automatic test_selector();
        for (int s = 0; s < 4; s++) begin
            rd(2'(s), 12'h04D, (s == 1) ? EXP : 8'h00, s != 1);
        end
        $display("test_selector done");
    endtask

    // Back-to-back commands, oversize ones on purpose
    task automatic test_size_gate();
        logic [3:0]  pg [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'hF, 4'hF, 4'hF};
        logic [31:0] db [9] = '{32'h20000, 32'h20001, 32'h1FF00, 32'h1FF00, 32'h20001, 32'h40001,
                                32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
        logic [31:0] mb [9] = '{32'h0, 32'h0, 32'h200, 32'h200, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h1, 32'h2};
        bit          il [9] = '{0, 0, 1, 0, 0, 0, 1, 1, 1};
        bit          ab [9] = '{0, 1, 1, 0, 0, 1, 1, 0, 1};
        ccr_cmd_t    c;
        for (int i = 0; i < 9; i++) begin
            @(negedge clk_in);
            min_page_exp = pg[i];
            c = '{valid: 1'b1, tag: 16'h0100 + 16'(i), data_bytes: db[i], meta_bytes: mb[i],
                  meta_interleaved: il[i]};
            host.cmd_beat(c);
            check(verdict, {1'b1, c.tag, ab[i], ab[i] ? INV : 8'h00}, "verdict");
            check(verdict_nolim, {1'b1, c.tag, 1'b0, 8'h00}, "unlimited verdict");
        end
        @(negedge clk_in);
        host.cmd_idle();
        @(posedge clk_in);
        #1;
        check({verdict.valid, verdict_nolim.valid}, 2'b00, "verdict one cycle only");
        $display("test_size_gate done");
    endtask

    initial begin
        sys_rst_in   = 1'b1;
        min_page_exp = 4'h0;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        @(posedge clk_in);
        #1;
        test_reset();
        test_identify();
        test_selector();
        test_size_gate();
        conclude();
    end
endmodule // tb_top
